//--- pkg/bmf_pkg.sv
// Shared constants and types for the bidirectional mailbox FIFO
package bmf_pkg;
  localparam int DATA_W = 36;
  localparam int DEPTH = 256;
  localparam int ADDR_W = 8;
  localparam int PTR_W = 9;
  localparam int OFS_W = 9;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 9'h100;
  localparam logic [PTR_W-1:0] PTR_RST = 9'h000;
  // Offset fields of a port A offset-load word
  localparam int AEB_OFS_POS = 0;
  localparam int AEA_OFS_POS = 9;
  localparam int AFA_OFS_POS = 18;
  localparam int AFB_OFS_POS = 27;
  localparam logic [OFS_W-1:0] OFS_RST = 9'h008;
  localparam logic [DATA_W-1:0] WORD_RST = 36'h0_0000_0000;
  // Flag values while held in reset
  localparam logic READY_RST = 1'b0;
  localparam logic ALMOST_EMPTY_N_RST = 1'b0;
  localparam logic ALMOST_FULL_N_RST = 1'b1;
  localparam logic MAIL_FLAG_N_RST = 1'b1;
  localparam int SYNC_W = 42;

  typedef struct packed {
    logic portClock;
    logic chipSelectN;
    logic enable;
    logic writeNotRead;
    logic mailboxSelect;
    logic offsetLoad;
    logic [DATA_W-1:0] busIn;
  } bmf_pin_t;

  typedef struct packed {
    logic inputReady;
    logic outputReady;
    logic almostFullN;
    logic almostEmptyN;
  } bmf_flags_t;
endpackage : bmf_pkg

//--- rtl/bmf_mailbox_fifo.sv
// Bidirectional mailbox FIFO: pin sync, two direction channels, port logic
// What this block does
// - Two 36-bit FIFOs, A-to-B and B-to-A.
// - Port clocks independent; coincident edges both work.
// - Transfers only on qualified own-port clock edges.
// - One 36-bit mailbox per direction, with flag.
// - Input-ready, almost-full synced to writer's clock.
// - Output-ready, almost-empty synced to reader's clock.
// - Port flags change only on own clock.
// - Flag offsets loadable only from port A.
// - a_almost_empty low when B-to-A count <= offset.
// - b_almost_empty low when A-to-B count <= offset.
// - a_almost_full low when A-to-B free <= offset.
// - b_almost_full low when B-to-A free <= offset.
// - One shared bus per port, never both driving.
// - Chip select high floats port A outputs.
// - Write-not-read picks direction; high floats outputs.
// - Mailbox select steers access to mailbox registers.
// - Mail flag low on write, high on read.

module bmf_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      dout <= '0;
    end else begin
      stage1_q <= din;
      dout <= stage1_q;
    end
  end
endmodule : bmf_sync

module bmf_dir
  import bmf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrTick,
  input wire logic wrStb,
  input wire logic wrMail,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdTick,
  input wire logic rdStb,
  input wire logic rdMail,
  input wire logic [OFS_W-1:0] aeOffset,
  input wire logic [OFS_W-1:0] afOffset,
  output logic [DATA_W-1:0] fifoHead,
  output logic [DATA_W-1:0] mailWord_q,
  output logic mailFlagN_q,
  output bmf_flags_t flags_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrBin_q, rdBin_q, wrGray_q, rdGray_q;
  logic [PTR_W-1:0] rdGrayS1_q, rdGrayS2_q, wrGrayS1_q, wrGrayS2_q;
  logic [PTR_W-1:0] wrNext, rdNext, wrCount, rdCount, wrFree;
  logic doWrite, doRead;

  function automatic logic [PTR_W-1:0] toGray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : toGray

  function automatic logic [PTR_W-1:0] toBin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction : toBin

  assign doWrite = wrStb && flags_q.inputReady;
  assign doRead = rdStb && flags_q.outputReady;
  assign wrNext = wrBin_q + PTR_W'(doWrite);
  assign rdNext = rdBin_q + PTR_W'(doRead);
  assign wrCount = wrNext - toBin(rdGrayS2_q);
  assign wrFree = DEPTH_CNT - wrCount;
  assign rdCount = toBin(wrGrayS2_q) - rdNext;
  assign fifoHead = mem[rdBin_q[ADDR_W-1:0]];

  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrBin_q[ADDR_W-1:0]] <= wrData;
    end
  end

  // Write side: pointer, Gray copy, reader pointer sync, flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrBin_q <= PTR_RST;
      wrGray_q <= PTR_RST;
      rdGrayS1_q <= PTR_RST;
      rdGrayS2_q <= PTR_RST;
      flags_q.inputReady <= READY_RST;
      flags_q.almostFullN <= ALMOST_FULL_N_RST;
    end else if (wrTick) begin
      wrBin_q <= wrNext;
      wrGray_q <= toGray(wrNext);
      rdGrayS1_q <= rdGray_q;
      rdGrayS2_q <= rdGrayS1_q;
      flags_q.inputReady <= (wrCount != DEPTH_CNT);
      flags_q.almostFullN <= !(wrFree <= afOffset);
    end
  end

  // Read side: pointer, Gray copy, writer pointer sync, flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdBin_q <= PTR_RST;
      rdGray_q <= PTR_RST;
      wrGrayS1_q <= PTR_RST;
      wrGrayS2_q <= PTR_RST;
      flags_q.outputReady <= READY_RST;
      flags_q.almostEmptyN <= ALMOST_EMPTY_N_RST;
    end else if (rdTick) begin
      rdBin_q <= rdNext;
      rdGray_q <= toGray(rdNext);
      wrGrayS1_q <= wrGray_q;
      wrGrayS2_q <= wrGrayS1_q;
      flags_q.outputReady <= (rdCount != PTR_RST);
      flags_q.almostEmptyN <= !(rdCount <= aeOffset);
    end
  end

  // Mailbox: new mail to an empty mailbox wins over a same-cycle read; with the flag low the read wins and the write is dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mailWord_q <= WORD_RST;
      mailFlagN_q <= MAIL_FLAG_N_RST;
    end else if (wrMail && mailFlagN_q) begin
      mailWord_q <= wrData;
      mailFlagN_q <= 1'b0;
    end else if (rdMail) begin
      mailFlagN_q <= 1'b1;
    end
  end

  sequence mailStore;
    wrMail && mailFlagN_q;
  endsequence

  sequence mailBlocked;
    wrMail && !mailFlagN_q && !rdMail;
  endsequence

  chk_mail_store: assert property (mailStore |=> !mailFlagN_q && mailWord_q == $past(wrData))
    else $error("mailbox write did not store or flag");
  chk_mail_inhibit: assert property (mailBlocked |=> $stable(mailWord_q) && !mailFlagN_q)
    else $error("mailbox overwritten while flag low");
  chk_write_flags: assert property (!wrTick |=> $stable(flags_q.inputReady) && $stable(flags_q.almostFullN))
    else $error("write side flag moved off its edge");
  chk_read_flags: assert property (!rdTick |=> $stable(flags_q.outputReady) && $stable(flags_q.almostEmptyN))
    else $error("read side flag moved off its edge");
  chk_gray_step: assert property (wrTick && doWrite |=> $onehot(wrGray_q ^ $past(wrGray_q)))
    else $error("write Gray pointer changed more than one bit");
  chk_no_overrun: assert property (wrTick && wrStb && !flags_q.inputReady |=> $stable(wrBin_q))
    else $error("write accepted while full");
  chk_empty_ae: assert property (!flags_q.outputReady |-> !flags_q.almostEmptyN)
    else $error("almost-empty deasserted on empty FIFO");
  chk_full_af: assert property ($past(wrTick) && !flags_q.inputReady |-> !flags_q.almostFullN)
    else $error("almost-full deasserted on full FIFO");
endmodule : bmf_dir

module bmf_mailbox_fifo
  import bmf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic portAClock,
  input wire logic aChipSelectN,
  input wire logic aEnable,
  input wire logic aWriteNotRead,
  input wire logic aMailboxSelect,
  input wire logic aOffsetLoad,
  input wire logic [DATA_W-1:0] portABusIn,
  output logic [DATA_W-1:0] portABusOut,
  output logic portABusOe,
  input wire logic portBClock,
  input wire logic bChipSelectN,
  input wire logic bEnable,
  input wire logic bWriteNotRead,
  input wire logic bMailboxSelect,
  input wire logic [DATA_W-1:0] portBBusIn,
  output logic [DATA_W-1:0] portBBusOut,
  output logic portBBusOe,
  output logic aInputReady,
  output logic aOutputReady,
  output logic aAlmostFullN,
  output logic aAlmostEmptyN,
  output logic bInputReady,
  output logic bOutputReady,
  output logic bAlmostFullN,
  output logic bAlmostEmptyN,
  output logic mailAbFlagN,
  output logic mailBaFlagN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  bmf_pin_t aPin, bPin;
  bmf_flags_t abFlags, baFlags;
  logic aClkPrev_q, bClkPrev_q, aTick, bTick, aQual, bQual;
  logic aWr, aRd, bWr, bRd;
  logic [OFS_W-1:0] aeAOfs_q, aeBOfs_q, afAOfs_q, afBOfs_q;
  logic [DATA_W-1:0] abHead, baHead, abMail, baMail;

  bmf_sync #(.W(SYNC_W)) syncA (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({portAClock, aChipSelectN, aEnable, aWriteNotRead, aMailboxSelect, aOffsetLoad,
          portABusIn}),
    .dout(aPin)
  );
  bmf_sync #(.W(SYNC_W)) syncB (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({portBClock, bChipSelectN, bEnable, bWriteNotRead, bMailboxSelect, 1'b0,
          portBBusIn}),
    .dout(bPin)
  );

  // Port clock rising edges as enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aClkPrev_q <= 1'b0;
      bClkPrev_q <= 1'b0;
    end else begin
      aClkPrev_q <= aPin.portClock;
      bClkPrev_q <= bPin.portClock;
    end
  end

  assign aTick = aPin.portClock && !aClkPrev_q;
  assign bTick = bPin.portClock && !bClkPrev_q;
  assign aQual = aTick && !aPin.chipSelectN && aPin.enable;
  assign bQual = bTick && !bPin.chipSelectN && bPin.enable;
  assign aWr = aQual && aPin.writeNotRead;
  assign aRd = aQual && !aPin.writeNotRead;
  assign bWr = bQual && bPin.writeNotRead;
  assign bRd = bQual && !bPin.writeNotRead;

  // Offsets load from port A only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aeAOfs_q <= OFS_RST;
      aeBOfs_q <= OFS_RST;
      afAOfs_q <= OFS_RST;
      afBOfs_q <= OFS_RST;
    end else if (aWr && aPin.offsetLoad) begin
      aeBOfs_q <= aPin.busIn[AEB_OFS_POS +: OFS_W];
      aeAOfs_q <= aPin.busIn[AEA_OFS_POS +: OFS_W];
      afAOfs_q <= aPin.busIn[AFA_OFS_POS +: OFS_W];
      afBOfs_q <= aPin.busIn[AFB_OFS_POS +: OFS_W];
    end
  end

  bmf_dir dirAb (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrTick(aTick),
    .wrStb(aWr && !aPin.mailboxSelect && !aPin.offsetLoad),
    .wrMail(aWr && aPin.mailboxSelect && !aPin.offsetLoad),
    .wrData(aPin.busIn),
    .rdTick(bTick),
    .rdStb(bRd && !bPin.mailboxSelect),
    .rdMail(bRd && bPin.mailboxSelect),
    .aeOffset(aeBOfs_q),
    .afOffset(afAOfs_q),
    .fifoHead(abHead),
    .mailWord_q(abMail),
    .mailFlagN_q(mailAbFlagN),
    .flags_q(abFlags)
  );
  bmf_dir dirBa (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrTick(bTick),
    .wrStb(bWr && !bPin.mailboxSelect),
    .wrMail(bWr && bPin.mailboxSelect),
    .wrData(bPin.busIn),
    .rdTick(aTick),
    .rdStb(aRd && !aPin.mailboxSelect),
    .rdMail(aRd && aPin.mailboxSelect),
    .aeOffset(aeAOfs_q),
    .afOffset(afBOfs_q),
    .fifoHead(baHead),
    .mailWord_q(baMail),
    .mailFlagN_q(mailBaFlagN),
    .flags_q(baFlags)
  );

  assign aInputReady = abFlags.inputReady;
  assign aAlmostFullN = abFlags.almostFullN;
  assign aOutputReady = baFlags.outputReady;
  assign aAlmostEmptyN = baFlags.almostEmptyN;
  assign bInputReady = baFlags.inputReady;
  assign bAlmostFullN = baFlags.almostFullN;
  assign bOutputReady = abFlags.outputReady;
  assign bAlmostEmptyN = abFlags.almostEmptyN;

  // Bus drivers: float on deselect or write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portABusOe <= 1'b0;
      portBBusOe <= 1'b0;
    end else begin
      portABusOe <= !aPin.chipSelectN && !aPin.writeNotRead;
      portBBusOe <= !bPin.chipSelectN && !bPin.writeNotRead;
    end
  end

  // Read words into the output registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portABusOut <= WORD_RST;
      portBBusOut <= WORD_RST;
    end else begin
      if (aRd && aPin.mailboxSelect) begin
        portABusOut <= baMail;
      end else if (aRd && baFlags.outputReady) begin
        portABusOut <= baHead;
      end
      if (bRd && bPin.mailboxSelect) begin
        portBBusOut <= abMail;
      end else if (bRd && abFlags.outputReady) begin
        portBBusOut <= abHead;
      end
    end
  end

  chk_a_float: assert property (aPin.chipSelectN |=> !portABusOe)
    else $error("port A bus driven while deselected");
endmodule : bmf_mailbox_fifo

//--- tb/bmf_port_agent.sv
// Port controller model that drives one port's pins of the mailbox FIFO
module bmf_port_agent
  import bmf_pkg::*;
(
  input wire logic mclk,
  input wire logic [DATA_W-1:0] busOut,
  output bmf_pin_t pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    pin = '0;
    pin.chipSelectN = 1'b1;
  end

  // One port clock cycle: controls held 4 mclk before and 5 after the rise
  task automatic op(input logic w, m, o, e, c, input logic [DATA_W-1:0] d,
                    output logic [DATA_W-1:0] q);
    @(posedge mclk);
    #1;
    pin.chipSelectN = c;
    pin.enable = e;
    pin.writeNotRead = w;
    pin.mailboxSelect = m;
    pin.offsetLoad = o;
    pin.busIn = w ? d : ~pin.busIn;
    repeat (4) @(posedge mclk);
    #1 pin.portClock = 1'b1;
    repeat (5) @(posedge mclk);
    #1 q = busOut;
    pin.portClock = 1'b0;
    pin.chipSelectN = 1'b1;
    pin.enable = 1'b0;
    pin.busIn = ~pin.busIn;
  endtask : op
endmodule : bmf_port_agent

//--- tb/tb.sv
// Self-checking testbench for the bidirectional mailbox FIFO
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end

module tb
  import bmf_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [DATA_W-1:0] W0 = 36'h1_2345_6780;
  localparam logic [DATA_W-1:0] W1 = 36'h9_8765_4320;
  localparam logic [DATA_W-1:0] MA = 36'ha_5a5a_5a5a;
  localparam logic [DATA_W-1:0] MB = 36'h3_c3c3_c3c3;
  localparam logic [DATA_W-1:0] OFS = (36'h002 << AEB_OFS_POS) | (36'h001 << AEA_OFS_POS)
                                    | (36'h0fd << AFA_OFS_POS) | (36'h0ff << AFB_OFS_POS);

  logic mclk;
  logic rst_n;
  bmf_pin_t pinA;
  bmf_pin_t pinB;
  logic [DATA_W-1:0] aBus;
  logic [DATA_W-1:0] bBus;
  logic [DATA_W-1:0] rq;
  int err_total = 0;
  int num_checks = 0;

  assign aBus = DUT.portABusOe ? DUT.portABusOut : pinA.busIn;
  assign bBus = DUT.portBBusOe ? DUT.portBBusOut : pinB.busIn;

  bmf_port_agent agA (.mclk(mclk), .busOut(aBus), .pin(pinA));
  bmf_port_agent agB (.mclk(mclk), .busOut(bBus), .pin(pinB));

  bmf_mailbox_fifo DUT (
    .mclk(mclk), .rst_n(rst_n),
    .portAClock(pinA.portClock), .aChipSelectN(pinA.chipSelectN), .aEnable(pinA.enable),
    .aWriteNotRead(pinA.writeNotRead), .aMailboxSelect(pinA.mailboxSelect),
    .aOffsetLoad(pinA.offsetLoad), .portABusIn(aBus), .portABusOut(), .portABusOe(),
    .portBClock(pinB.portClock), .bChipSelectN(pinB.chipSelectN), .bEnable(pinB.enable),
    .bWriteNotRead(pinB.writeNotRead), .bMailboxSelect(pinB.mailboxSelect),
    .portBBusIn(bBus), .portBBusOut(), .portBBusOe(),
    .aInputReady(), .aOutputReady(), .aAlmostFullN(), .aAlmostEmptyN(),
    .bInputReady(), .bOutputReady(), .bAlmostFullN(), .bAlmostEmptyN(),
    .mailAbFlagN(), .mailBaFlagN()
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic xa(input logic w, m, o, e, c, input logic [DATA_W-1:0] d);
    agA.op(w, m, o, e, c, d, rq);
  endtask : xa

  task automatic xb(input logic w, m, e, c, input logic [DATA_W-1:0] d);
    agB.op(w, m, 1'b0, e, c, d, rq);
  endtask : xb

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("aAlmostEmptyN", ALMOST_EMPTY_N_RST, DUT.aAlmostEmptyN)
    `CHK("aAlmostFullN", ALMOST_FULL_N_RST, DUT.aAlmostFullN)
    `CHK("bInputReady", READY_RST, DUT.bInputReady)
    `CHK("mailAbFlagN", MAIL_FLAG_N_RST, DUT.mailAbFlagN)
    `CHK("portABusOe", 1'b0, DUT.portABusOe)
    #1 rst_n = 1'b1;
    // Idle ticks on both ports at once
    fork
      repeat (2) xa(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0);
      repeat (2) xb(1'b0, 1'b0, 1'b0, 1'b1, '0);
    join
    `CHK("aInputReady", 1'b1, DUT.aInputReady)
    `CHK("bInputReady", 1'b1, DUT.bInputReady)
    `CHK("bAlmostEmptyN", 1'b0, DUT.bAlmostEmptyN)
    // Offsets, then three words A to B
    xa(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, OFS);
    for (int i = 0; i < 3; i++) begin
      xa(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, W0 + DATA_W'(i));
      if (i == 1)
        `CHK("aAlmostFullN", 1'b1, DUT.aAlmostFullN)
    end
    `CHK("aAlmostFullN", 1'b0, DUT.aAlmostFullN)
    `CHK("portABusOe", 1'b0, DUT.portABusOe)
    // Unqualified writes must not land
    xa(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, ~W0);
    xa(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ~W0);
    repeat (3) xb(1'b0, 1'b0, 1'b0, 1'b1, '0);
    `CHK("bOutputReady", 1'b1, DUT.bOutputReady)
    `CHK("bAlmostEmptyN", 1'b1, DUT.bAlmostEmptyN)
    for (int i = 0; i < 3; i++) begin
      xb(1'b0, 1'b0, 1'b1, 1'b0, '0);
      `CHK("portBBusOut", W0 + DATA_W'(i), rq)
      if (i == 0)
        `CHK("bAlmostEmptyN", 1'b0, DUT.bAlmostEmptyN)
    end
    repeat (3) xb(1'b0, 1'b0, 1'b0, 1'b1, '0);
    `CHK("bOutputReady", 1'b0, DUT.bOutputReady)
    // Mailboxes written on coincident port edges
    fork
      xa(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, MA);
      xb(1'b1, 1'b1, 1'b1, 1'b0, MB);
    join
    `CHK("mailAbFlagN", 1'b0, DUT.mailAbFlagN)
    `CHK("mailBaFlagN", 1'b0, DUT.mailBaFlagN)
    xa(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, ~MA);
    xb(1'b0, 1'b1, 1'b1, 1'b0, '0);
    `CHK("portBBusOut", MA, rq)
    `CHK("portBBusOe", 1'b1, DUT.portBBusOe)
    `CHK("mailAbFlagN", 1'b1, DUT.mailAbFlagN)
    xa(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, '0);
    `CHK("portABusOut", MB, rq)
    `CHK("mailBaFlagN", 1'b1, DUT.mailBaFlagN)
    // B to A FIFO
    `CHK("bAlmostFullN", 1'b1, DUT.bAlmostFullN)
    xb(1'b1, 1'b0, 1'b1, 1'b0, W1);
    `CHK("bAlmostFullN", 1'b0, DUT.bAlmostFullN)
    xb(1'b1, 1'b0, 1'b1, 1'b0, W1 + 36'h1);
    `CHK("portBBusOe", 1'b0, DUT.portBBusOe)
    repeat (3) xa(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0);
    `CHK("aOutputReady", 1'b1, DUT.aOutputReady)
    `CHK("aAlmostEmptyN", 1'b1, DUT.aAlmostEmptyN)
    xa(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, '0);
    `CHK("portABusOut", W1, rq)
    `CHK("aAlmostEmptyN", 1'b0, DUT.aAlmostEmptyN)
    `CHK("portABusOe", 1'b1, DUT.portABusOe)
    xa(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, '0);
    `CHK("portABusOut", W1 + 36'h1, rq)
    `CHK("aOutputReady", 1'b0, DUT.aOutputReady)
    xa(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, '0);
    `CHK("portABusOe", 1'b0, DUT.portABusOe)
    complete_run();
  end
endmodule : tb
